/* File: rtl/jtag_emu_port.sv */
// Test access port, emulator pins and global output-off control.
module jtag_emu_port (
    input  wire logic i_clk,
    input  wire logic i_nrst,
    input  wire logic i_tck,
    input  wire logic i_test_rst_n,
    input  wire logic i_tms,
    input  wire logic i_tdi,
    output logic      o_tdo,
    output logic      o_tdo_oe,
    input  wire logic i_emulator_pin0,
    output logic      o_emulator_pin0,
    output logic      o_emulator_pin0_oe,
    input  wire logic i_emulator_pin1_output_disable,
    output logic      o_emulator_pin1_output_disable,
    output logic      o_emulator_pin1_output_disable_oe,
    input  wire logic i_host_port_ready,
    output logic      o_host_port_ready,
    output logic      o_host_port_ready_oe,
    output logic      o_outputs_off,
    output logic      o_scan_mode,
    output logic      o_emulator_pin0_irq,
    output logic      o_emu1_irq
);
    import jtag_emu_pkg::*;

    tap_state_t state;
    tap_state_t next_state;
    logic [1:0] tck_pin0_sync;
    logic [1:0] tck_pin1_sync;
    logic [IR_W-1:0]  instr;
    logic [EMU_W-1:0] emu_value;
    emu_ctrl_t  emu_ctrl;
    logic       ir_tdo_bit;
    logic       bypass_tdo_bit;
    logic       id_tdo_bit;
    logic       emu_tdo_bit;
    pin_sync_t  pins_meta;
    pin_sync_t  pins;

    // TAP controller, held in its reset state while test reset is low.
    always_comb begin
        case (state)
            TLR:        next_state = i_tms ? TLR : RTI;
            RTI:        next_state = i_tms ? SEL_DR : RTI;
            SEL_DR:     next_state = i_tms ? SEL_IR : CAPTURE_DR;
            CAPTURE_DR: next_state = i_tms ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR:   next_state = i_tms ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR:   next_state = i_tms ? UPDATE_DR : PAUSE_DR;
            PAUSE_DR:   next_state = i_tms ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR:   next_state = i_tms ? UPDATE_DR : SHIFT_DR;
            UPDATE_DR:  next_state = i_tms ? SEL_DR : RTI;
            SEL_IR:     next_state = i_tms ? TLR : CAPTURE_IR;
            CAPTURE_IR: next_state = i_tms ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR:   next_state = i_tms ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR:   next_state = i_tms ? UPDATE_IR : PAUSE_IR;
            PAUSE_IR:   next_state = i_tms ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR:   next_state = i_tms ? UPDATE_IR : SHIFT_IR;
            UPDATE_IR:  next_state = i_tms ? SEL_DR : RTI;
            default:    next_state = TLR;
        endcase
    end

    always_ff @(posedge i_tck or negedge i_test_rst_n) begin
        if (!i_test_rst_n) begin
            state <= TLR;
        end else begin
            state <= next_state;
        end
    end

    // Emulator pins cross into the test clock domain before use.
    always_ff @(posedge i_tck or negedge i_test_rst_n) begin
        if (!i_test_rst_n) begin
            tck_pin0_sync <= 2'h0;
            tck_pin1_sync <= 2'h0;
        end else begin
            tck_pin0_sync <= {tck_pin0_sync[0], i_emulator_pin0};
            tck_pin1_sync <= {tck_pin1_sync[0],
                              i_emulator_pin1_output_disable};
        end
    end

    wire sel_id     = (instr == OP_IDCODE);
    wire sel_emu    = (instr == OP_EMU_CTRL);
    wire sel_bypass = !sel_id && !sel_emu;
    wire cap_dr     = (state == CAPTURE_DR);
    wire sh_dr      = (state == SHIFT_DR);
    wire up_dr      = (state == UPDATE_DR);
    wire shifting   = (state == SHIFT_DR) || (state == SHIFT_IR);
    wire [EMU_W-1:0] emu_capture = {tck_pin1_sync[1], emu_ctrl.pin1_dir,
                                    tck_pin0_sync[1], emu_ctrl.pin0_dir};

    scan_reg #(.W(IR_W), .RST(IR_RESET)) u_ir (
        .i_tck         (i_tck),
        .i_test_rst_n  (i_test_rst_n),
        .i_capture     (state == CAPTURE_IR),
        .i_shift       (state == SHIFT_IR),
        .i_update      (state == UPDATE_IR),
        .i_tdi         (i_tdi),
        .i_capture_val (IR_CAPTURE),
        .o_tdo_bit     (ir_tdo_bit),
        .o_value       (instr)
    );

    scan_reg #(.W(1), .RST(BYPASS_CAPTURE)) u_bypass (
        .i_tck         (i_tck),
        .i_test_rst_n  (i_test_rst_n),
        .i_capture     (cap_dr && sel_bypass),
        .i_shift       (sh_dr && sel_bypass),
        .i_update      (1'b0),
        .i_tdi         (i_tdi),
        .i_capture_val (BYPASS_CAPTURE),
        .o_tdo_bit     (bypass_tdo_bit),
        .o_value       ()
    );

    scan_reg #(.W(ID_W), .RST(ID_CODE)) u_idcode (
        .i_tck         (i_tck),
        .i_test_rst_n  (i_test_rst_n),
        .i_capture     (cap_dr && sel_id),
        .i_shift       (sh_dr && sel_id),
        .i_update      (1'b0),
        .i_tdi         (i_tdi),
        .i_capture_val (ID_CODE),
        .o_tdo_bit     (id_tdo_bit),
        .o_value       ()
    );

    scan_reg #(.W(EMU_W), .RST(EMU_CTRL_RESET)) u_emu_ctrl (
        .i_tck         (i_tck),
        .i_test_rst_n  (i_test_rst_n),
        .i_capture     (cap_dr && sel_emu),
        .i_shift       (sh_dr && sel_emu),
        .i_update      (up_dr && sel_emu),
        .i_tdi         (i_tdi),
        .i_capture_val (emu_capture),
        .o_tdo_bit     (emu_tdo_bit),
        .o_value       (emu_value)
    );

    assign emu_ctrl = emu_ctrl_t'(emu_value);

    // Scan-set direction and level; test reset low clears them, so pin1
    // turns back into a pure input as soon as the output-off role applies.
    assign o_emulator_pin0                   = emu_ctrl.pin0_out;
    assign o_emulator_pin0_oe                = emu_ctrl.pin0_dir;
    assign o_emulator_pin1_output_disable    = emu_ctrl.pin1_out;
    assign o_emulator_pin1_output_disable_oe = emu_ctrl.pin1_dir;

    wire dr_bit  = sel_id ? id_tdo_bit : (sel_emu ? emu_tdo_bit
                                                  : bypass_tdo_bit);
    wire out_bit = (state == SHIFT_IR) ? ir_tdo_bit : dr_bit;

    // Falling edge launch gives the controller half a period of set-up.
    always_ff @(negedge i_tck or negedge i_test_rst_n) begin
        if (!i_test_rst_n) begin
            o_tdo    <= 1'b0;
            o_tdo_oe <= 1'b0;
        end else begin
            o_tdo    <= out_bit;
            o_tdo_oe <= shifting && tck_pin1_sync[1];
        end
    end

    // System clock side: pins pass two flip-flops before any decode.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pins_meta <= pin_sync_t'(PIN_SYNC_RESET);
            pins      <= pin_sync_t'(PIN_SYNC_RESET);
        end else begin
            pins_meta <= '{test_rst_n: i_test_rst_n,
                           emulator_pin0:       i_emulator_pin0,
                           emu1:       i_emulator_pin1_output_disable};
            pins      <= pins_meta;
        end
    end

    // Off needs pin0 high as well, so a stray low on pin1 alone is harmless.
    wire off_request = !pins.test_rst_n && pins.emulator_pin0 && !pins.emu1;
    wire emu_active  = pins.test_rst_n;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_outputs_off        <= 1'b0;
            o_scan_mode          <= 1'b0;
            o_host_port_ready    <= 1'b0;
            o_host_port_ready_oe <= 1'b0;
            o_emulator_pin0_irq           <= 1'b0;
            o_emu1_irq           <= 1'b0;
        end else begin
            o_outputs_off        <= off_request;
            o_scan_mode          <= emu_active;
            o_host_port_ready    <= i_host_port_ready;
            o_host_port_ready_oe <= !off_request;
            o_emulator_pin0_irq           <= emu_active && !pins.emulator_pin0;
            o_emu1_irq           <= emu_active && !pins.emu1;
        end
    end

    property p_tap_reset;
        @(posedge i_tck) disable iff (!i_test_rst_n)
        i_tms [*5] |=> (state == TLR);
    endproperty
    a_tap_reset: assert property (p_tap_reset)
        else $error("Five high mode selects did not reach reset state.");

    property p_bypass_sample;
        @(posedge i_tck) disable iff (!i_test_rst_n)
        (sh_dr && sel_bypass) |=> (bypass_tdo_bit == $past(i_tdi));
    endproperty
    a_bypass_sample: assert property (p_bypass_sample)
        else $error("Bypass stage did not take the data input.");

    property p_tdo_launch;
        @(negedge i_tck) disable iff (!i_test_rst_n)
        (state == SHIFT_IR) |=> (o_tdo == $past(ir_tdo_bit));
    endproperty
    a_tdo_launch: assert property (p_tdo_launch)
        else $error("Data output did not follow the shifted bit.");

    property p_tdo_float;
        @(posedge i_tck) disable iff (!i_test_rst_n)
        o_tdo_oe |-> shifting;
    endproperty
    a_tdo_float: assert property (p_tdo_float)
        else $error("Data output driven outside a shift.");

    property p_tdo_off;
        @(posedge i_tck) disable iff (!i_test_rst_n)
        !tck_pin1_sync[1] |-> !o_tdo_oe;
    endproperty
    a_tdo_off: assert property (p_tdo_off)
        else $error("Data output driven while pin1 low.");

    property p_scan_mode;
        @(posedge i_clk) disable iff (!i_nrst)
        pins.test_rst_n |=> o_scan_mode ##1 ($past(pins.test_rst_n, 1)
                                             == o_scan_mode);
    endproperty
    a_scan_mode: assert property (p_scan_mode)
        else $error("Scan mode not given while test reset high.");

    property p_functional;
        @(posedge i_clk) disable iff (!i_nrst)
        !pins.test_rst_n |=> !o_scan_mode && !o_emulator_pin0_irq && !o_emu1_irq;
    endproperty
    a_functional: assert property (p_functional)
        else $error("Scan behaviour seen in functional mode.");

    property p_off_entry;
        @(posedge i_clk) disable iff (!i_nrst)
        (!pins.test_rst_n && pins.emulator_pin0 && !pins.emu1) |=> o_outputs_off;
    endproperty
    a_off_entry: assert property (p_off_entry)
        else $error("Output-off not raised for the off condition.");

    property p_off_only_functional;
        @(posedge i_clk) disable iff (!i_nrst)
        pins.test_rst_n |=> !o_outputs_off;
    endproperty
    a_off_only_functional: assert property (p_off_only_functional)
        else $error("Output-off raised while pin1 is an emulator line.");

    property p_ready_float;
        @(posedge i_clk) disable iff (!i_nrst)
        (!pins.test_rst_n && pins.emulator_pin0 && !pins.emu1) |=> !o_host_port_ready_oe;
    endproperty
    a_ready_float: assert property (p_ready_float)
        else $error("Host ready driven during output-off.");

    property p_emu_irq;
        @(posedge i_clk) disable iff (!i_nrst)
        (pins.test_rst_n && !pins.emulator_pin0) |=> o_emulator_pin0_irq;
    endproperty
    a_emu_irq: assert property (p_emu_irq)
        else $error("Emulator interrupt on pin0 not reported.");

    property p_pin1_irq;
        @(posedge i_clk) disable iff (!i_nrst)
        (pins.test_rst_n && !pins.emu1) |=> o_emu1_irq;
    endproperty
    a_pin1_irq: assert property (p_pin1_irq)
        else $error("Emulator interrupt on pin1 not reported.");

    c_shift_ir: cover property (@(posedge i_tck) disable iff
        (!i_test_rst_n) state == SHIFT_IR ##1 state == SHIFT_IR);
    c_update_emu: cover property (@(posedge i_tck) disable iff
        (!i_test_rst_n) up_dr && sel_emu);
    c_outputs_off: cover property (@(posedge i_clk) disable iff
        (!i_nrst) $rose(o_outputs_off));
    c_emu_irq: cover property (@(posedge i_clk) disable iff
        (!i_nrst) $rose(o_emu1_irq));

endmodule : jtag_emu_port

/* File: rtl/jtag_emu_pkg.sv */
// Shared constants and types for the test access and emulator pin block.
package jtag_emu_pkg;

    localparam int          IR_W           = 4;
    localparam logic [3:0]  IR_CAPTURE     = 4'h1;
    localparam logic [3:0]  OP_IDCODE      = 4'h1;
    localparam logic [3:0]  OP_EMU_CTRL    = 4'h2;
    localparam logic [3:0]  OP_BYPASS      = 4'hF;
    localparam logic [3:0]  IR_RESET       = OP_IDCODE;
    // Identification value is arbitrary; bit 0 is one as scan chains expect.
    localparam logic [31:0] ID_CODE        = 32'h0A5A_5001;
    localparam int          ID_W           = 32;
    localparam int          EMU_W          = 4;
    localparam logic [3:0]  EMU_CTRL_RESET = 4'h0;
    localparam logic [0:0]  BYPASS_CAPTURE = 1'h0;
    localparam logic [2:0]  PIN_SYNC_RESET = 3'h0;
    localparam int          TAP_RESET_TMS  = 5;

    typedef struct packed {
        logic pin1_out;
        logic pin1_dir;
        logic pin0_out;
        logic pin0_dir;
    } emu_ctrl_t;

    typedef struct packed {
        logic test_rst_n;
        logic emulator_pin0;
        logic emu1;
    } pin_sync_t;

    typedef enum logic [15:0] {
        TLR        = 16'h0001,
        RTI        = 16'h0002,
        SEL_DR     = 16'h0004,
        CAPTURE_DR = 16'h0008,
        SHIFT_DR   = 16'h0010,
        EXIT1_DR   = 16'h0020,
        PAUSE_DR   = 16'h0040,
        EXIT2_DR   = 16'h0080,
        UPDATE_DR  = 16'h0100,
        SEL_IR     = 16'h0200,
        CAPTURE_IR = 16'h0400,
        SHIFT_IR   = 16'h0800,
        EXIT1_IR   = 16'h1000,
        PAUSE_IR   = 16'h2000,
        EXIT2_IR   = 16'h4000,
        UPDATE_IR  = 16'h8000
    } tap_state_t;

endpackage : jtag_emu_pkg

/* File: rtl/scan_reg.sv */
// One scan register with capture, shift and update stages on the test clock.
module scan_reg #(
    parameter int         W   = 4,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         i_tck,
    input  wire logic         i_test_rst_n,
    input  wire logic         i_capture,
    input  wire logic         i_shift,
    input  wire logic         i_update,
    input  wire logic         i_tdi,
    input  wire logic [W-1:0] i_capture_val,
    output logic              o_tdo_bit,
    output logic [W-1:0]      o_value
);
    logic [W-1:0] sh;
    logic [W-1:0] next_shift;

    generate
        if (W > 1) begin : g_wide
            assign next_shift = {i_tdi, sh[W-1:1]};
        end else begin : g_single
            assign next_shift = i_tdi;
        end
    endgenerate

    assign o_tdo_bit = sh[0];

    always_ff @(posedge i_tck or negedge i_test_rst_n) begin
        if (!i_test_rst_n) begin
            sh <= RST;
        end else if (i_capture) begin
            sh <= i_capture_val;
        end else if (i_shift) begin
            sh <= next_shift;
        end
    end

    // Update on the rising edge keeps this register on one edge polarity.
    always_ff @(posedge i_tck or negedge i_test_rst_n) begin
        if (!i_test_rst_n) begin
            o_value <= RST;
        end else if (i_update) begin
            o_value <= sh;
        end
    end

endmodule : scan_reg

/* File: tb/jtag_ctrl_model.sv */
// Behavioural test and emulation controller that drives the scan pins.
module jtag_ctrl_model (
    output logic      o_tck,
    output logic      o_tms,
    output logic      o_tdi,
    output logic      o_test_rst_n,
    output logic      o_pin0_wire,
    output logic      o_pin1_wire,
    input  wire logic i_pin0_dev,
    input  wire logic i_pin0_dev_oe,
    input  wire logic i_pin1_dev,
    input  wire logic i_pin1_dev_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    logic drv0;
    logic drv1;

    // Both pins are pulled up, so the controller's idle drive is high.
    assign o_pin0_wire = i_pin0_dev_oe ? i_pin0_dev : drv0;
    assign o_pin1_wire = i_pin1_dev_oe ? i_pin1_dev : drv1;

    initial begin
        o_tck        = 1'b0;
        o_tms        = 1'b1;
        o_tdi        = 1'b1;
        o_test_rst_n = 1'b0;
        drv0         = 1'b1;
        drv1         = 1'b1;
    end

    task automatic set_pins(input logic t, input logic p0, input logic p1);
        o_test_rst_n = t;
        drv0         = p0;
        drv1         = p1;
    endtask : set_pins

    // Inputs change while the clock is low, well clear of the rising edge.
    task automatic tick_bit(input logic m, input logic d);
        o_tms = m;
        o_tdi = d;
        #40 o_tck = 1'b1;
        #40 o_tck = 1'b0;
    endtask : tick_bit

    task automatic tlr();
        repeat (5) tick_bit(1'b1, 1'b1);
        tick_bit(1'b0, 1'b1);
    endtask : tlr

    task automatic scan(input logic ir, input logic [31:0] din, input int n);
        #3;
        tick_bit(1'b1, 1'b1);
        if (ir) begin
            tick_bit(1'b1, 1'b1);
        end
        tick_bit(1'b0, 1'b1);
        tick_bit(1'b0, 1'b1);
        for (int i = 0; i < n; i++) begin
            tick_bit(i == n - 1, din[i]);
        end
        tick_bit(1'b1, 1'b1);
        tick_bit(1'b0, 1'b1);
        o_tms = 1'b1;
        o_tdi = 1'b1;
    endtask : scan
endmodule : jtag_ctrl_model

/* File: tb/jtag_emulation_output_off_test.sv */
// Self-checking bench for the test access port and output-off logic.
`define CHECK(what, exp, got) \
    begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("unexpected %s: expected %h seen %h", what, exp, got); end end

module jtag_emulation_output_off_test;
    timeunit 1ns;
    timeprecision 100ps;
    import jtag_emu_pkg::*;

    logic       i_clk, i_nrst, tck, tms, tdi, trst_n, pin0_w, pin1_w;
    logic       tdo, tdo_oe, p0_out, p0_oe, p1_out, p1_oe;
    logic       host_port_ready, host_port_ready_out, host_port_ready_oe, off, scan, irq0, irq1, bit_exp;
    logic [9:0] sx;
    logic [9:0] sy;
    logic [31:0] rnd;
    logic       tdo_q[$];
    logic [9:0] sys_q[$];
    event       sys_ev;
    int         fail_count = 0;
    int         total_checks = 0;
    int         seed = 23;

    jtag_ctrl_model u_ctl (
        .o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_test_rst_n(trst_n),
        .o_pin0_wire(pin0_w), .o_pin1_wire(pin1_w),
        .i_pin0_dev(p0_out), .i_pin0_dev_oe(p0_oe),
        .i_pin1_dev(p1_out), .i_pin1_dev_oe(p1_oe)
    );

    jtag_emu_port u_dut (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_tck(tck),
        .i_test_rst_n(trst_n), .i_tms(tms), .i_tdi(tdi),
        .o_tdo(tdo), .o_tdo_oe(tdo_oe),
        .i_emulator_pin0(pin0_w), .o_emulator_pin0(p0_out),
        .o_emulator_pin0_oe(p0_oe),
        .i_emulator_pin1_output_disable(pin1_w),
        .o_emulator_pin1_output_disable(p1_out),
        .o_emulator_pin1_output_disable_oe(p1_oe),
        .i_host_port_ready(host_port_ready), .o_host_port_ready(host_port_ready_out),
        .o_host_port_ready_oe(host_port_ready_oe), .o_outputs_off(off),
        .o_scan_mode(scan), .o_emulator_pin0_irq(irq0), .o_emu1_irq(irq1)
    );

    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    function automatic logic [9:0] sys_exp(logic t, logic p0, logic p1,
                                           logic h, emu_ctrl_t e);
        logic w0, w1, o;
        w0 = (t && e.pin0_dir) ? e.pin0_out : p0;
        w1 = (t && e.pin1_dir) ? e.pin1_out : p1;
        o  = !t && w0 && !w1;
        return {o, !o, h, t, t && !w0, t && !w1, e};
    endfunction : sys_exp

    task automatic push_bits(input logic [31:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            tdo_q.push_back(v[i]);
        end
    endtask : push_bits

    // Pin levels cross two sync flops and one output flop before they show.
    task automatic expect_sys(input logic t, input logic p0, input logic p1,
                              input emu_ctrl_t e);
        @(negedge i_clk);
        host_port_ready = 1'($random(seed));
        u_ctl.set_pins(t, p0, p1);
        sys_q.push_back(sys_exp(t, p0, p1, host_port_ready, e));
        repeat (4) @(negedge i_clk);
        -> sys_ev;
    endtask : expect_sys

    task automatic ir_load(input logic [3:0] op);
        push_bits({28'h0, IR_CAPTURE}, IR_W);
        u_ctl.scan(1'b1, {28'h0, op}, IR_W);
    endtask : ir_load

    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    always @(posedge tck) begin
        if (tdo_oe === 1'b1) begin
            if (tdo_q.size() == 0) begin
                `CHECK("tdo enable", 1'b0, tdo_oe)
            end else begin
                bit_exp = tdo_q.pop_front();
                `CHECK("tdo", bit_exp, tdo)
            end
        end
    end

    always @(sys_ev) begin
        sx = sys_q.pop_front();
        sy = {off, host_port_ready_oe, host_port_ready_out, scan, irq0, irq1,
              p1_out, p1_oe, p0_out, p0_oe};
        `CHECK("system pins", sx, sy)
    end

    initial begin
        i_nrst = 1'b0;
        host_port_ready   = 1'b0;
        repeat (20) @(negedge i_clk);
        i_nrst = 1'b1;
        for (int k = 0; k < 8; k++) begin
            expect_sys(k[2], k[1], k[0], 4'h0);
        end
        expect_sys(1'b0, 1'b1, 1'b1, 4'h0);
        u_ctl.scan(1'b0, 32'h0, 8);
        expect_sys(1'b1, 1'b1, 1'b1, 4'h0);
        u_ctl.tlr();
        rnd = $random(seed);
        push_bits(ID_CODE, ID_W);
        u_ctl.scan(1'b0, rnd, ID_W);
        ir_load(OP_BYPASS);
        rnd = $random(seed);
        push_bits({rnd[30:0], BYPASS_CAPTURE}, 8);
        u_ctl.scan(1'b0, rnd, 8);
        ir_load(OP_EMU_CTRL);
        push_bits(32'hA, EMU_W);
        u_ctl.scan(1'b0, 32'h3, EMU_W);
        expect_sys(1'b1, 1'b1, 1'b1, 4'h3);
        expect_sys(1'b1, 1'b1, 1'b0, 4'h3);
        u_ctl.scan(1'b1, {28'h0, OP_BYPASS}, IR_W);
        expect_sys(1'b1, 1'b1, 1'b1, 4'h3);
        ir_load(OP_IDCODE);
        expect_sys(1'b0, 1'b1, 1'b1, 4'h0);
        expect_sys(1'b1, 1'b1, 1'b1, 4'h0);
        `CHECK("tdo bits left", 0, tdo_q.size())
        stop_test();
    end

    initial begin
        #100us;
        fail_count++;
        $display("watchdog expired");
        stop_test();
    end
endmodule : jtag_emulation_output_off_test
